/* File: common/pwm_level_pkg.sv */
// constants for the pwm output level control block
package pwm_level_pkg;
  localparam logic [3:0] ADDR_LEVEL_CTRL_1 = 4'h0;
  localparam logic [3:0] ADDR_LEVEL_CTRL_2 = 4'h1;
  localparam logic [3:0] ADDR_STATUS       = 4'h2;
  localparam int BIT_POS_LEVEL   = 0;
  localparam int BIT_REV_LEVEL   = 1;
  localparam int BIT_SRC_SEL     = 2;
  localparam int BIT_WRITE_LOCK  = 3;
  localparam int BIT_TOGGLE_EN   = 6;
  localparam logic [7:0] LEVEL_CTRL_1_RESET = 8'h00;
  localparam logic [7:0] LEVEL_CTRL_1_MASK  = 8'h4F;
  localparam logic [7:0] LEVEL_CTRL_2_RESET = 8'h00;
  localparam int DEAD_TIME_NS = 100;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int DEAD_TIME_CYCLES = (DEAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [15:0] DEAD_TIME_CYCLES_W = 16'(DEAD_TIME_CYCLES);
endpackage : pwm_level_pkg

/* File: core/phase_level_map.sv */
// maps level select bit, count phase and compare match onto pin levels
`timescale 1ns/10ps
module phase_level_map (
  input  wire logic sel_pos,       // positive phase level select
  input  wire logic sel_rev,       // reverse phase level select
  input  wire logic match_up,      // compare match while counting up
  input  wire logic match_down,    // compare match while counting down
  input  wire logic pos_now,       // current positive level
  input  wire logic rev_now,       // current reverse level
  output logic      pos_next,      // next positive level
  output logic      rev_next,      // next reverse level
  output logic      pos_init,      // positive initial level
  output logic      rev_init,      // reverse initial level
  output logic      rev_active     // reverse active level
);
  always_comb begin
    pos_init   = ~sel_pos;
    rev_init   = ~sel_rev;
    rev_active = sel_rev;
    pos_next   = pos_now;
    rev_next   = rev_now;
    if (match_up) begin
      pos_next = sel_pos;
      rev_next = ~sel_rev;
    end else if (match_down) begin
      pos_next = ~sel_pos;
      rev_next = sel_rev;
    end
  end
endmodule : phase_level_map

/* File: core/pwm_output_level_control.sv */
// output level control register and pwm pin level logic
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module pwm_output_level_control #(
  parameter logic [15:0] DEAD_CYCLES = pwm_level_pkg::DEAD_TIME_CYCLES_W
) (
  input  wire logic       clock,        // 100 MHz clock
  input  wire logic       rst,          // async reset, active high
  input  wire logic       clk_en,       // freezes all state when low
  input  wire logic [3:0] addr,         // register address
  input  wire logic [7:0] wdata,        // write data
  input  wire logic       wr,           // write strobe
  input  wire logic       rd,           // read strobe
  output logic      [7:0] rdata,        // read data, cycle after rd
  input  wire logic       count_start,  // counter start pulse
  input  wire logic       count_run,    // counter running level
  input  wire logic       match_up,     // compare match counting up
  input  wire logic       match_down,   // compare match counting down
  input  wire logic       period_edge,  // pwm period boundary pulse
  output logic            pos_out,      // positive phase pin level
  output logic            rev_out,      // reverse phase pin level
  output logic            toggle_out    // period synchronised toggle
);
  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl2_r;
  // one-hot run phase: idle while the counter is stopped, dead while the
  // reverse phase is held back, live once the dead time has gone by
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_DEAD = 3'h2,
    PH_LIVE = 3'h4
  } phase_e;
  phase_e      phase_r;
  phase_e      phase_nxt;
  logic [15:0] dead_cnt_r;
  logic        dead_end;
  logic        live;
  logic        pos_nxt;
  logic        rev_nxt;
  logic        pos_init;
  logic        rev_init;
  logic        rev_active;
  logic        sel_pos;
  logic        sel_rev;
  logic        wr1;
  logic        wr2;
  logic [7:0]  ctrl1_nxt;

  // address match, shared by the write decodes of both registers
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
    return a == target;
  endfunction : addr_hit

  assign wr1 = wr && addr_hit(addr, pwm_level_pkg::ADDR_LEVEL_CTRL_1);
  assign wr2 = wr && addr_hit(addr, pwm_level_pkg::ADDR_LEVEL_CTRL_2);

  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl1_nxt[pwm_level_pkg::BIT_TOGGLE_EN] = wdata[pwm_level_pkg::BIT_TOGGLE_EN];
    if (!ctrl1_r[pwm_level_pkg::BIT_WRITE_LOCK]) begin
      ctrl1_nxt[pwm_level_pkg::BIT_SRC_SEL]   = wdata[pwm_level_pkg::BIT_SRC_SEL];
      ctrl1_nxt[pwm_level_pkg::BIT_REV_LEVEL] = wdata[pwm_level_pkg::BIT_REV_LEVEL];
      ctrl1_nxt[pwm_level_pkg::BIT_POS_LEVEL] = wdata[pwm_level_pkg::BIT_POS_LEVEL];
    end
    // lock is sticky: a written 0 is ignored
    ctrl1_nxt[pwm_level_pkg::BIT_WRITE_LOCK] = ctrl1_r[pwm_level_pkg::BIT_WRITE_LOCK] |
                                               wdata[pwm_level_pkg::BIT_WRITE_LOCK];
    ctrl1_nxt = ctrl1_nxt & pwm_level_pkg::LEVEL_CTRL_1_MASK;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl1_r <= pwm_level_pkg::LEVEL_CTRL_1_RESET;
    end else if (clk_en && wr1) begin
      ctrl1_r <= ctrl1_nxt;
    end
  end

  // stand-in for the second per-pin register: only its pair for this channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl2_r <= pwm_level_pkg::LEVEL_CTRL_2_RESET;
    end else if (clk_en && wr2) begin
      ctrl2_r <= wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (clk_en) begin
      if (!rd) begin
        rdata <= 8'h00;
      end else begin
        case (addr)
          pwm_level_pkg::ADDR_LEVEL_CTRL_1: rdata <= ctrl1_r & pwm_level_pkg::LEVEL_CTRL_1_MASK;
          pwm_level_pkg::ADDR_LEVEL_CTRL_2: rdata <= ctrl2_r;
          pwm_level_pkg::ADDR_STATUS:       rdata <= {5'h00, live, rev_out, pos_out};
          default:                          rdata <= 8'h00;
        endcase
      end
    end
  end

  // source select picks which pair of level bits drives the mapping
  assign sel_pos = ctrl1_r[pwm_level_pkg::BIT_SRC_SEL] ? ctrl2_r[0] : ctrl1_r[pwm_level_pkg::BIT_POS_LEVEL];
  assign sel_rev = ctrl1_r[pwm_level_pkg::BIT_SRC_SEL] ? ctrl2_r[1] : ctrl1_r[pwm_level_pkg::BIT_REV_LEVEL];

  phase_level_map u_map (
    .sel_pos    (sel_pos),
    .sel_rev    (sel_rev),
    .match_up   (match_up),
    .match_down (match_down),
    .pos_now    (pos_out),
    .rev_now    (rev_out),
    .pos_next   (pos_nxt),
    .rev_next   (rev_nxt),
    .pos_init   (pos_init),
    .rev_init   (rev_init),
    .rev_active (rev_active)
  );

  assign live = (phase_r == PH_LIVE);

  // the dead time ends on the edge that takes the reverse phase live
  assign dead_end = (dead_cnt_r + 16'h0001) >= DEAD_CYCLES;

  // a counter brought up without a start pulse still waits out the
  // dead time, so the reverse phase can never skip it
  always_comb begin
    phase_nxt = phase_r;
    if (!count_run) begin
      phase_nxt = PH_IDLE;
    end else if (count_start) begin
      phase_nxt = PH_DEAD;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          phase_nxt = PH_DEAD;
        end
        PH_DEAD: begin
          if (dead_end) begin
            phase_nxt = PH_LIVE;
          end
        end
        PH_LIVE: begin
          phase_nxt = PH_LIVE;
        end
        default: begin
          phase_nxt = PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_r <= PH_IDLE;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
    end
  end

  // counts only while the reverse phase is held back, so a restart
  // always begins a full dead time from zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dead_cnt_r <= 16'h0000;
    end else if (clk_en) begin
      if (phase_r == PH_DEAD && count_run && !count_start) begin
        dead_cnt_r <= dead_cnt_r + 16'h0001;
      end else begin
        dead_cnt_r <= 16'h0000;
      end
    end
  end

  // positive phase follows compare matches in each running cycle without a start pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_out <= 1'b1;
    end else if (clk_en) begin
      if (!count_run || count_start) begin
        pos_out <= pos_init;
      end else begin
        pos_out <= pos_nxt;
      end
    end
  end

  // reverse phase sits at its initial level through the dead time; a
  // match that lands inside the dead time is not applied to it, so the
  // active level never shows before the dead time is over
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rev_out <= 1'b1;
    end else if (clk_en) begin
      if (!count_run || count_start) begin
        rev_out <= rev_init;
      end else begin
        case (phase_r)
          PH_DEAD: begin
            if (dead_end) begin
              rev_out <= rev_active;
            end else begin
              rev_out <= rev_init;
            end
          end
          PH_LIVE: begin
            rev_out <= rev_nxt;
          end
          default: begin
            rev_out <= rev_init;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      toggle_out <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl1_r[pwm_level_pkg::BIT_TOGGLE_EN]) begin
        toggle_out <= 1'b0;
      end else if (period_edge) begin
        toggle_out <= ~toggle_out;
      end
    end
  end

endmodule : pwm_output_level_control

/* File: tb/pwm_level_checker.sv */
// port assertions for the output level control block
`timescale 1ns/10ps
module pwm_level_checker #(
  parameter logic [15:0] DEAD_CYCLES = pwm_level_pkg::DEAD_TIME_CYCLES_W
) (
  input wire logic       clock,        // block clock
  input wire logic       rst,          // async reset, active high
  input wire logic       clk_en,       // state freeze when low
  input wire logic       wr,           // write strobe
  input wire logic       rd,           // read strobe
  input wire logic       count_start,  // counter start pulse
  input wire logic       count_run,    // counter running level
  input wire logic       match_up,     // up-count compare match
  input wire logic       match_down,   // down-count compare match
  input wire logic       period_edge,  // pwm period boundary
  input wire logic [3:0] addr,         // register address
  input wire logic [7:0] wdata,        // write data
  input wire logic [7:0] rdata,        // read data
  input wire logic       pos_out,      // positive phase pin
  input wire logic       rev_out,      // reverse phase pin
  input wire logic       toggle_out    // synchronised toggle pin
);
  logic       tog_r;
  logic       lock_r;
  logic [2:0] lvl_r;
  logic [15:0] cyc_r;
  wire        we0 = wr && clk_en && addr == pwm_level_pkg::ADDR_LEVEL_CTRL_1;
  wire        rd0 = rd && clk_en && addr == pwm_level_pkg::ADDR_LEVEL_CTRL_1;
  // shadow of the register; level bits frozen once the lock is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tog_r <= 1'b0;
      lock_r <= 1'b0;
      lvl_r <= 3'h0;
    end else if (we0) begin
      tog_r <= wdata[6];
      lock_r <= lock_r | wdata[3];
      if (!lock_r) lvl_r <= wdata[2:0];
    end
  end
  // edges since count start, saturating; 1 on the first edge after the start
  always_ff @(posedge clock or posedge rst) begin
    if (rst) cyc_r <= 16'h0000;
    else if (clk_en) begin
      if (!count_run) cyc_r <= 16'h0000;
      else if (count_start) cyc_r <= 16'h0001;
      else if (cyc_r != 16'h0000 && cyc_r != 16'hFFFF) cyc_r <= cyc_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rsvd; rdata[7] == 1'b0 && rdata[5:4] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_tog; tog_r && period_edge && clk_en |=> toggle_out != $past(toggle_out); endproperty
  a_tog: assert property (p_tog) else $error("toggle missed period edge");
  property p_lock; rd0 |=> rdata[3] == $past(lock_r); endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_prot; rd0 |=> rdata[2:0] == $past(lvl_r); endproperty
  a_prot: assert property (p_prot) else $error("protected bits wrong");
  property p_tgrd; rd0 |=> rdata[6] == $past(tog_r); endproperty
  a_tgrd: assert property (p_tgrd) else $error("toggle enable bit wrong");
  property p_pinit; (!count_run && clk_en && !lvl_r[2] && $stable(lvl_r))[*2] |-> pos_out == !lvl_r[0]; endproperty
  a_pinit: assert property (p_pinit) else $error("positive initial level wrong");
  property p_rinit; (!count_run && clk_en && !lvl_r[2] && $stable(lvl_r))[*2] |-> rev_out == !lvl_r[1]; endproperty
  a_rinit: assert property (p_rinit) else $error("reverse initial level wrong");
  property p_pup; count_run && clk_en && match_up && !match_down && !lvl_r[2] |=> pos_out == $past(lvl_r[0]); endproperty
  a_pup: assert property (p_pup) else $error("positive up match level wrong");
  property p_dead; count_start && count_run && clk_en && !lvl_r[2] |=> (rev_out == !lvl_r[1])[*2]; endproperty
  a_dead: assert property (p_dead) else $error("reverse left initial level early");
  property p_live;
    count_run && !count_start && clk_en && !lvl_r[2] && cyc_r == DEAD_CYCLES |=> rev_out == $past(lvl_r[1]);
  endproperty
  a_live: assert property (p_live) else $error("reverse missed active level after dead time");
endmodule : pwm_level_checker

/* File: tb/tb.sv */
// self-checking bench for the output level control block
`timescale 1ns/10ps
module tb;
  logic       clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, count_start = 1'b0, count_run = 1'b0;
  logic       clk_en = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [2:0] ev = 3'h0;
  logic       pos_out, rev_out, toggle_out;
  int         n_errors = 0, comparisons = 0;
  pwm_output_level_control #(.DEAD_CYCLES(16'h0003)) dut (.clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .count_start(count_start), .count_run(count_run),
    .match_up(ev[1]), .match_down(ev[0]), .period_edge(ev[2]), .pos_out(pos_out), .rev_out(rev_out),
    .toggle_out(toggle_out));
  initial forever #5 clock = ~clock;
  task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp) begin n_errors++; $display("Error %0t: read %h expected %h", $time, act, exp); end
  endtask : chk8
  task automatic chk1(input logic act, input logic exp);
    comparisons++;
    if (act !== exp) begin n_errors++; $display("Error %0t: pin %b expected %b", $time, act, exp); end
  endtask : chk1
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock); wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock); addr <= a; rd <= 1'b1;
    @(posedge clock); rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask : rreg
  // one-cycle event pulse, then two edges so registered pins settle
  task automatic pulse(input logic [2:0] e);
    @(posedge clock); ev <= e;
    @(posedge clock); ev <= 3'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask : pulse
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin #200000; n_errors++; stop_test(); end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    #1 chk1(pos_out, 1'b1);
    chk1(rev_out, 1'b1);
    rreg(4'h0, pwm_level_pkg::LEVEL_CTRL_1_RESET);
    $display("test reset done");
    wreg(4'h0, 8'h07);
    rreg(4'h0, 8'h07);
    repeat (3) @(posedge clock);
    #1 chk1(pos_out, 1'b1);
    chk1(rev_out, 1'b1);
    wreg(4'h1, 8'h03);
    repeat (3) @(posedge clock);
    #1 chk1(pos_out, 1'b0);
    chk1(rev_out, 1'b0);
    wreg(4'h0, 8'h03);
    repeat (3) @(posedge clock);
    #1 chk1(pos_out, 1'b0);
    chk1(rev_out, 1'b0);
    $display("test source and polarity done");
    pulse(3'h4);
    chk1(toggle_out, 1'b0);
    wreg(4'h0, 8'h43);
    pulse(3'h4);
    chk1(toggle_out, 1'b1);
    $display("test toggle done");
    @(posedge clock); count_run <= 1'b1; count_start <= 1'b1;
    @(posedge clock); count_start <= 1'b0;
    #1 chk1(rev_out, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk1(rev_out, 1'b0);
    @(posedge clock);
    #1 chk1(rev_out, 1'b1);
    rreg(pwm_level_pkg::ADDR_STATUS, 8'h06);
    pulse(3'h1);
    chk1(pos_out, 1'b0);
    chk1(rev_out, 1'b1);
    pulse(3'h2);
    chk1(pos_out, 1'b1);
    chk1(rev_out, 1'b0);
    @(posedge clock); count_run <= 1'b0;
    $display("test run done");
    wreg(4'h0, 8'h08);
    rreg(4'h0, 8'h08);
    wreg(4'h0, 8'h47);
    rreg(4'h0, 8'h48);
    repeat (3) @(posedge clock);
    #1 chk1(pos_out, 1'b1);
    $display("test lock done");
    @(posedge clock); clk_en <= 1'b0;
    wreg(4'h0, 8'h08);
    clk_en <= 1'b1;
    rreg(4'h0, 8'h48);
    $display("test clock enable done");
    stop_test();
  end
endmodule : tb
bind pwm_output_level_control pwm_level_checker #(.DEAD_CYCLES(DEAD_CYCLES)) chk (.clock(clock), .rst(rst),
  .clk_en(clk_en), .wr(wr), .rd(rd), .count_start(count_start), .count_run(count_run), .match_up(match_up),
  .match_down(match_down), .period_edge(period_edge), .addr(addr), .wdata(wdata), .rdata(rdata),
  .pos_out(pos_out), .rev_out(rev_out), .toggle_out(toggle_out));
